// ==== verilog/eeprom_pkg.sv ====
`default_nettype none
package eeprom_pkg;
	// clocking and self-timed write
	localparam int CLK_HZ = 40_000_000;
	localparam int CLK_PERIOD_NS = 25;
	localparam int OSC_HZ = 1_000_000;
	localparam int OSC_DIV_DEF = CLK_HZ / OSC_HZ;
	localparam int WRITE_OSC_CYCLES_DEF = 8448;

	// array geometry
	localparam int EE_DEPTH = 1024;
	localparam int ADDR_W = 10;
	localparam int ADDR_HI_W = ADDR_W - 8;

	// control register layout
	localparam int CTRL_RIE_BIT = 3;
	localparam int CTRL_MWE_BIT = 2;
	localparam int CTRL_WS_BIT = 1;
	localparam int CTRL_RS_BIT = 0;
	localparam logic [7:0] CTRL_RSVD_MASK = 8'hF0;
	localparam logic [7:0] CTRL_RIE_MASK = 8'h08;
	localparam logic [7:0] CTRL_MWE_MASK = 8'h04;
	localparam logic [7:0] CTRL_WS_MASK = 8'h02;
	localparam logic [7:0] CTRL_RS_MASK = 8'h01;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	// cycle counts on the cpu clock
	localparam int CNT_W = 3;
	localparam logic [CNT_W-1:0] MWE_TIMEOUT = 3'h4;
	localparam logic [CNT_W-1:0] WR_STALL = 3'h2;
	localparam logic [CNT_W-1:0] RD_STALL = 3'h4;
	localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
	localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;

	// register select on the i/o link
	typedef enum logic [1:0] {
		SEL_CTRL,
		SEL_ADDR_LO,
		SEL_ADDR_HI,
		SEL_DATA
	} reg_sel_t;
endpackage
`default_nettype wire

// ==== verilog/eeprom_link_if.sv ====
`default_nettype none
interface eeprom_link_if;
	import eeprom_pkg::*;
	reg_sel_t sel;
	logic wr;
	logic rd;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic rd_valid;
	logic stall;
	logic irq;
	logic global_ie;
	logic flash_busy;
	logic powerdown;
	logic pd_held;

	modport device (
		input sel, wr, rd, wdata, global_ie, flash_busy, powerdown,
		output rdata, rd_valid, stall, irq, pd_held
	);
	modport host (
		output sel, wr, rd, wdata, global_ie, flash_busy, powerdown,
		input rdata, rd_valid, stall, irq, pd_held
	);
endinterface
`default_nettype wire

// ==== verilog/eeprom_write_timer.sv ====
`default_nettype none
module eeprom_write_timer #(
	parameter int DIV = 40,
	parameter int COUNT = 8448
) (
	input wire logic i_clk,
	input wire logic i_por,
	input wire logic i_ce,
	input wire logic i_start,
	output logic o_done
);
	localparam int PW = $clog2(DIV);
	localparam int CW = $clog2(COUNT + 1);

	logic run_r;
	logic [PW-1:0] pre_r;
	logic [CW-1:0] cnt_r;
	logic tick;

	// divider stands in for the calibrated 1 MHz oscillator
	assign tick = (pre_r == PW'(DIV - 1));
	assign o_done = run_r && tick && (cnt_r == CW'(COUNT - 1));

	// only power-on clears it, so a write runs through a core reset
	always_ff @(posedge i_clk) begin
		if (i_por) begin
			run_r <= 1'b0;
			pre_r <= '0;
			cnt_r <= '0;
		end else if (i_ce) begin
			if (i_start) begin
				run_r <= 1'b1;
				pre_r <= '0;
				cnt_r <= '0;
			end else if (run_r) begin
				pre_r <= tick ? '0 : PW'(pre_r + 1'b1);
				if (tick)
					cnt_r <= CW'(cnt_r + 1'b1);
				if (o_done)
					run_r <= 1'b0;
			end
		end
	end
endmodule // eeprom_write_timer
`default_nettype wire

// ==== verilog/eeprom_device.sv ====
`default_nettype none
// How it works
// - control bits seven to four read zero
// - ready interrupt held while write strobe clear
// - strobe starts write only within enable window
// - master enable self-clears four cycles later
// - valid strobe writes data byte at address
// - strobe reads one until write completes
// - write lasts 8448 one-megahertz oscillator cycles
// - write start stalls cpu two cycles
// - read strobe loads byte, stalls four cycles
// - busy write ignores reads and address changes
// - no write starts while flash programming
// - software follows poll, load, enable, strobe
// - software masks interrupts during write sequence
// - software polls strobe before reading
// - write finishes in power-down, oscillator kept
// - write in progress survives a reset
// - ten-bit linear address, upper bits zero
// - data register feeds writes, receives reads
module eeprom_device
	import eeprom_pkg::*;
#(
	parameter int WRITE_OSC_CYCLES = WRITE_OSC_CYCLES_DEF,
	parameter int OSC_DIV = OSC_DIV_DEF
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_por,
	input wire logic i_ce,
	eeprom_link_if.device link,
	output logic o_write_active,
	output logic o_write_done
);

	function automatic logic hit(input logic strobe, input reg_sel_t sel, input reg_sel_t code);
		return strobe && (sel == code);
	endfunction

	logic ctrl_wr;
	logic alo_wr;
	logic ahi_wr;
	logic data_wr;
	logic mwe_active;
	logic write_go;
	logic read_go;
	logic timer_done;
	logic rst_any;
	logic irq_en_r;
	logic [CNT_W-1:0] mwe_cnt_r;
	logic busy_r;
	logic rs_r;
	logic [ADDR_W-1:0] addr_r;
	logic [ADDR_W-1:0] wr_addr_r;
	logic [7:0] data_r;
	logic [7:0] wr_data_r;
	logic [7:0] rdata_r;
	logic rvalid_r;
	logic pd_held_r;
	logic [CNT_W-1:0] stall_cnt_r;
	logic [7:0] ctrl_image;
	logic [7:0] mem [EE_DEPTH];

	// access decode; the clock enable gates every strobe
	assign ctrl_wr = hit(link.wr && i_ce, link.sel, SEL_CTRL);
	assign alo_wr = hit(link.wr && i_ce, link.sel, SEL_ADDR_LO);
	assign ahi_wr = hit(link.wr && i_ce, link.sel, SEL_ADDR_HI);
	assign data_wr = hit(link.wr && i_ce, link.sel, SEL_DATA);
	assign rst_any = i_srst || i_por;
	assign mwe_active = (mwe_cnt_r != CNT_ZERO);

	// strobe honoured only inside the window, idle, flash quiet
	assign write_go = ctrl_wr && link.wdata[CTRL_WS_BIT] && mwe_active
		&& !busy_r && !link.flash_busy;
	// write wins if both strobes arrive together
	assign read_go = ctrl_wr && link.wdata[CTRL_RS_BIT] && !busy_r && !write_go;

	// ready irq is a level, not a pulse: it re-fires until masked
	assign link.irq = irq_en_r && link.global_ie && !busy_r;
	assign link.stall = (stall_cnt_r != CNT_ZERO);
	assign link.rdata = rdata_r;
	assign link.rd_valid = rvalid_r;
	assign link.pd_held = pd_held_r;
	assign o_write_active = busy_r;
	assign o_write_done = timer_done;

	// readback image of the control register
	always_comb begin
		ctrl_image = BYTE_ZERO;
		ctrl_image[CTRL_RIE_BIT] = irq_en_r;
		ctrl_image[CTRL_MWE_BIT] = mwe_active;
		ctrl_image[CTRL_WS_BIT] = busy_r;
		ctrl_image[CTRL_RS_BIT] = rs_r;
	end

	// ready interrupt enable
	always_ff @(posedge i_clk) begin
		if (rst_any) begin
			irq_en_r <= 1'b0;
		end else if (ctrl_wr) begin
			irq_en_r <= link.wdata[CTRL_RIE_BIT];
		end
	end

	// master enable window, re-armed by each write of one
	always_ff @(posedge i_clk) begin
		if (rst_any) begin
			mwe_cnt_r <= CNT_ZERO;
		end else if (i_ce) begin
			if (ctrl_wr) begin
				mwe_cnt_r <= link.wdata[CTRL_MWE_BIT] ? MWE_TIMEOUT : CNT_ZERO;
			end else if (mwe_active) begin
				mwe_cnt_r <= CNT_W'(mwe_cnt_r - CNT_ONE);
			end
		end
	end

	// write engine: snapshots address and data at start
	// core reset is not seen here so a write in flight completes
	always_ff @(posedge i_clk) begin
		if (i_por) begin
			busy_r <= 1'b0;
			wr_addr_r <= '0;
			wr_data_r <= BYTE_ZERO;
		end else if (i_ce) begin
			if (write_go) begin
				busy_r <= 1'b1;
				wr_addr_r <= addr_r;
				wr_data_r <= data_r;
			end else if (timer_done) begin
				busy_r <= 1'b0;
			end
		end
	end

	// self-timed duration from the oscillator divider
	eeprom_write_timer #(
		.DIV(OSC_DIV),
		.COUNT(WRITE_OSC_CYCLES)
	) u_timer (
		.i_clk(i_clk),
		.i_por(i_por),
		.i_ce(i_ce),
		.i_start(write_go),
		.o_done(timer_done)
	);

	// array commit at end of the access time
	always_ff @(posedge i_clk) begin
		if (i_ce && timer_done) begin
			mem[wr_addr_r] <= wr_data_r;
		end
	end

	// address register, frozen while a write is busy
	always_ff @(posedge i_clk) begin
		if (rst_any) begin
			addr_r <= '0;
		end else begin
			if (alo_wr && !busy_r) begin
				addr_r[7:0] <= link.wdata;
			end
			if (ahi_wr && !busy_r) begin
				addr_r[ADDR_W-1:8] <= link.wdata[ADDR_HI_W-1:0];
			end
		end
	end

	// data register: cpu loads it, a read strobe overwrites it
	always_ff @(posedge i_clk) begin
		if (rst_any) begin
			data_r <= BYTE_ZERO;
		end else if (read_go) begin
			data_r <= mem[addr_r];
		end else if (data_wr) begin
			data_r <= link.wdata;
		end
	end

	// read strobe flag and cpu stall counter
	always_ff @(posedge i_clk) begin
		if (rst_any) begin
			rs_r <= 1'b0;
			stall_cnt_r <= CNT_ZERO;
		end else if (i_ce) begin
			rs_r <= read_go;
			if (write_go) begin
				stall_cnt_r <= WR_STALL;
			end else if (read_go) begin
				stall_cnt_r <= RD_STALL;
			end else if (link.stall) begin
				stall_cnt_r <= CNT_W'(stall_cnt_r - CNT_ONE);
			end
		end
	end

	// register readback, one cycle after the read request
	always_ff @(posedge i_clk) begin
		if (rst_any) begin
			rdata_r <= BYTE_ZERO;
			rvalid_r <= 1'b0;
		end else if (i_ce) begin
			rvalid_r <= link.rd;
			if (link.rd) begin
				unique case (link.sel)
					SEL_CTRL: rdata_r <= ctrl_image & ~CTRL_RSVD_MASK;
					SEL_ADDR_LO: rdata_r <= addr_r[7:0];
					SEL_ADDR_HI: rdata_r <= {{(8 - ADDR_HI_W){1'b0}}, addr_r[ADDR_W-1:8]};
					SEL_DATA: rdata_r <= data_r;
				endcase
			end
		end
	end

	// a write ending in power-down leaves the oscillator held on
	always_ff @(posedge i_clk) begin
		if (i_por) begin
			pd_held_r <= 1'b0;
		end else if (i_ce) begin
			if (timer_done && link.powerdown) begin
				pd_held_r <= 1'b1;
			end else if (!link.powerdown) begin
				pd_held_r <= 1'b0;
			end
		end
	end

endmodule // eeprom_device
`default_nettype wire

// ==== verilog/eeprom_host.sv ====
`default_nettype none
module eeprom_host
	import eeprom_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_ce,
	eeprom_link_if.host link,
	input wire logic i_start_write,
	input wire logic i_start_read,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [7:0] i_data,
	input wire logic i_irq_enable,
	input wire logic i_global_ie,
	input wire logic i_flash_busy,
	input wire logic i_powerdown,
	output logic o_ready,
	output logic o_done,
	output logic [7:0] o_rdata,
	output logic o_irq,
	output logic o_pd_held
);

	typedef enum logic [3:0] {
		ST_IDLE, ST_POLL_REQ, ST_POLL_WAIT, ST_FLASH_WAIT, ST_ADDR_LO, ST_ADDR_HI,
		ST_DATA, ST_MWE, ST_WSTROBE, ST_RSTROBE, ST_DATA_REQ, ST_DATA_WAIT, ST_FINISH
	} host_state_t;

	host_state_t state_r;
	logic is_write_r;
	logic [ADDR_W-1:0] addr_r;
	logic [7:0] data_r;
	logic [7:0] rdata_r;
	logic done_r;
	logic wr_r;
	logic rd_r;
	reg_sel_t sel_r;
	logic [7:0] wdata_r;
	logic can_go;
	logic [7:0] ctrl_base;

	// one access in flight, and none while the core is stalled
	assign can_go = !link.stall && !wr_r && !rd_r;
	assign ctrl_base = i_irq_enable ? CTRL_RIE_MASK : BYTE_ZERO;

	assign link.sel = sel_r;
	assign link.wr = wr_r;
	assign link.rd = rd_r;
	assign link.wdata = wdata_r;
	// interrupts masked for the whole sequence
	assign link.global_ie = i_global_ie && (state_r == ST_IDLE);
	assign link.flash_busy = i_flash_busy;
	assign link.powerdown = i_powerdown;
	assign o_ready = (state_r == ST_IDLE);
	assign o_done = done_r;
	assign o_rdata = rdata_r;
	assign o_irq = link.irq;
	assign o_pd_held = link.pd_held;

	// access sequencer
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			state_r <= ST_IDLE;
			is_write_r <= 1'b0;
			addr_r <= '0;
			data_r <= BYTE_ZERO;
			rdata_r <= BYTE_ZERO;
			done_r <= 1'b0;
			wr_r <= 1'b0;
			rd_r <= 1'b0;
			sel_r <= SEL_CTRL;
			wdata_r <= BYTE_ZERO;
		end else if (i_ce) begin
			wr_r <= 1'b0;
			rd_r <= 1'b0;
			done_r <= 1'b0;
			unique case (state_r)
				ST_IDLE: if (i_start_write || i_start_read) begin
					is_write_r <= i_start_write;
					addr_r <= i_addr;
					data_r <= i_data;
					state_r <= ST_POLL_REQ;
				end
				ST_POLL_REQ: if (can_go) begin
					rd_r <= 1'b1;
					sel_r <= SEL_CTRL;
					state_r <= ST_POLL_WAIT;
				end
				// busy strobe means try again
				ST_POLL_WAIT: if (link.rd_valid) begin
					if (link.rdata[CTRL_WS_BIT])
						state_r <= ST_POLL_REQ;
					else
						state_r <= is_write_r ? ST_FLASH_WAIT : ST_ADDR_LO;
				end
				ST_FLASH_WAIT: if (!i_flash_busy) begin
					state_r <= ST_ADDR_LO;
				end
				ST_ADDR_LO: if (can_go) begin
					wr_r <= 1'b1;
					sel_r <= SEL_ADDR_LO;
					wdata_r <= addr_r[7:0];
					state_r <= ST_ADDR_HI;
				end
				ST_ADDR_HI: if (can_go) begin
					wr_r <= 1'b1;
					sel_r <= SEL_ADDR_HI;
					wdata_r <= {{(8 - ADDR_HI_W){1'b0}}, addr_r[ADDR_W-1:8]};
					state_r <= is_write_r ? ST_DATA : ST_RSTROBE;
				end
				ST_DATA: if (can_go) begin
					wr_r <= 1'b1;
					sel_r <= SEL_DATA;
					wdata_r <= data_r;
					state_r <= ST_MWE;
				end
				// enable with strobe zero, strobe two cycles later
				ST_MWE: if (can_go) begin
					wr_r <= 1'b1;
					sel_r <= SEL_CTRL;
					wdata_r <= ctrl_base | CTRL_MWE_MASK;
					state_r <= ST_WSTROBE;
				end
				ST_WSTROBE: if (can_go) begin
					wr_r <= 1'b1;
					sel_r <= SEL_CTRL;
					wdata_r <= ctrl_base | CTRL_MWE_MASK | CTRL_WS_MASK;
					state_r <= ST_FINISH;
				end
				ST_RSTROBE: if (can_go) begin
					wr_r <= 1'b1;
					sel_r <= SEL_CTRL;
					wdata_r <= ctrl_base | CTRL_RS_MASK;
					state_r <= ST_DATA_REQ;
				end
				ST_DATA_REQ: if (can_go) begin
					rd_r <= 1'b1;
					sel_r <= SEL_DATA;
					state_r <= ST_DATA_WAIT;
				end
				ST_DATA_WAIT: if (link.rd_valid) begin
					rdata_r <= link.rdata;
					state_r <= ST_FINISH;
				end
				ST_FINISH: if (can_go) begin
					done_r <= 1'b1;
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

endmodule // eeprom_host
`default_nettype wire

// ==== test/eeprom_access_control_chk.sv ====
`default_nettype none
module eeprom_access_control_chk
	import eeprom_pkg::*;
#(
	parameter int WRITE_OSC_CYCLES = WRITE_OSC_CYCLES_DEF,
	parameter int OSC_DIV = OSC_DIV_DEF
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire reg_sel_t sel,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic rd_valid,
	input wire logic stall,
	input wire logic irq,
	input wire logic global_ie,
	input wire logic flash_busy,
	input wire logic powerdown,
	input wire logic pd_held,
	input wire logic o_write_active,
	input wire logic o_write_done
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int WRITE_LEN = WRITE_OSC_CYCLES * OSC_DIV;
	logic [2:0] win_r;
	int wa_cnt_r;
	logic ctrl_wr;
	logic strobe_ok;
	// a strobe counts only inside the window and with flash idle
	assign ctrl_wr = wr && sel == SEL_CTRL;
	assign strobe_ok = ctrl_wr && wdata[1] && win_r != 3'h0 && !flash_busy;
	// enable window as software sees it
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			win_r <= 3'h0;
		end else if (ctrl_wr) begin
			win_r <= wdata[2] ? 3'h4 : 3'h0;
		end else if (win_r != 3'h0) begin
			win_r <= win_r - 3'h1;
		end
	end
	// no reset: a write outlives the core reset
	always_ff @(posedge i_clk) begin
		if (o_write_active) begin
			wa_cnt_r <= wa_cnt_r + 1;
		end else begin
			wa_cnt_r <= 0;
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_srst);
	a_rsvd_ctrl: assert property (rd_valid && $past(sel) == SEL_CTRL |-> rdata[7:4] == 4'h0)
		else $error("reserved control bits not zero");
	a_addr_upper: assert property (rd_valid && $past(sel) == SEL_ADDR_HI |-> rdata[7:2] == 6'h00)
		else $error("upper address bits not zero");
	a_irq_quiet: assert property ((o_write_active || !global_ie) |-> !irq)
		else $error("ready irq while busy or masked");
	a_strobe_cause: assert property ($rose(o_write_active) |-> $past(strobe_ok))
		else $error("write began without valid strobe");
	a_strobe_start: assert property (strobe_ok && !o_write_active |=> $rose(o_write_active))
		else $error("valid strobe did not start write");
	a_write_stall: assert property ($rose(o_write_active) |-> stall [*2] ##1 !stall)
		else $error("write stall not two cycles");
	a_write_len: assert property ($fell(o_write_active) |-> wa_cnt_r == WRITE_LEN)
		else $error("write time wrong");
	a_read_stall: assert property (ctrl_wr && wdata[0] && !wdata[1] && !o_write_active
		|=> stall [*4] ##1 !stall)
		else $error("read stall not four cycles");
	a_pd_hold: assert property ($fell(o_write_active) && powerdown |-> ##[0:1] pd_held)
		else $error("power-down hold flag missing");
	a_done_pulse: assert property ($fell(o_write_active) |-> $past(o_write_done))
		else $error("write ended without done pulse");
	a_gie_masked: assert property ((wr || rd) |-> !global_ie)
		else $error("interrupts open during access sequence");
	a_strobe_idle: assert property (ctrl_wr && (wdata[CTRL_WS_BIT] || wdata[CTRL_RS_BIT])
		|-> !o_write_active)
		else $error("strobe issued while write busy");
endmodule // eeprom_access_control_chk
`default_nettype wire

// ==== test/eeprom_access_control_tb_top.sv ====
`default_nettype none
module eeprom_access_control_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int OSC_N = 4;
	localparam int DIV_N = 2;
	logic i_clk, i_srst, i_por, start_w, start_r, irq_en, gie, fbusy, pdn;
	logic ready, done, irq, pd_held, wact, wdone, host_ce;
	logic [9:0] addr;
	logic [7:0] data, rdata;
	int errors, n_tests;
	logic [7:0] mem [int];
	eeprom_link_if link ();
	eeprom_device #(.WRITE_OSC_CYCLES(OSC_N), .OSC_DIV(DIV_N)) eeprom_device_i (
		.i_clk(i_clk), .i_srst(i_srst), .i_por(i_por), .i_ce(1'b1), .link(link),
		.o_write_active(wact), .o_write_done(wdone));
	eeprom_host eeprom_host_i (.i_clk(i_clk), .i_srst(i_srst), .i_ce(host_ce), .link(link),
		.i_start_write(start_w), .i_start_read(start_r), .i_addr(addr), .i_data(data),
		.i_irq_enable(irq_en), .i_global_ie(gie), .i_flash_busy(fbusy),
		.i_powerdown(pdn), .o_ready(ready), .o_done(done), .o_rdata(rdata),
		.o_irq(irq), .o_pd_held(pd_held));
	eeprom_access_control_chk #(.WRITE_OSC_CYCLES(OSC_N), .OSC_DIV(DIV_N)) chk_i (
		.i_clk(i_clk), .i_srst(i_srst), .sel(link.sel), .wr(link.wr), .rd(link.rd),
		.wdata(link.wdata), .rdata(link.rdata), .rd_valid(link.rd_valid),
		.stall(link.stall), .irq(link.irq), .global_ie(link.global_ie),
		.flash_busy(link.flash_busy), .powerdown(link.powerdown),
		.pd_held(link.pd_held), .o_write_active(wact), .o_write_done(wdone));
	// 40 MHz
	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end
	// compare and count
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// sampled 1 ns after the edge so the edge's updates have landed
	task automatic wait_lvl(ref logic s, input logic lvl);
		for (int i = 0; i < 4000 && s !== lvl; i++) begin
			@(posedge i_clk);
			#1;
		end
		if (s !== lvl) begin
			errors++;
			$display("FAIL t=%0t wait ran out", $time);
			report_and_stop();
		end
	endtask
	task automatic start_op(input logic w, input logic [9:0] a, input logic [7:0] d);
		wait_lvl(ready, 1'b1);
		@(posedge i_clk);
		start_w <= w;
		start_r <= !w;
		addr <= a;
		data <= d;
		@(posedge i_clk);
		start_w <= 1'b0;
		start_r <= 1'b0;
	endtask
	// model only learns a byte once the host reports the op finished
	task automatic op(input logic w, input logic [9:0] a, input logic [7:0] d);
		start_op(w, a, d);
		wait_lvl(done, 1'b1);
		if (w) mem[a] = d;
	endtask
	task automatic rd_chk(input logic [9:0] a);
		op(1'b0, a, 8'h00);
		check(rdata, mem[a]);
	endtask
	task automatic drive(input logic [3:0] v);
		@(posedge i_clk);
		{irq_en, gie, fbusy, pdn} <= v;
	endtask
	// catch the host just after its enable write, then spoil the strobe:
	// a frozen host lets the window lapse, raised flash busy bars the write
	task automatic spoil_strobe(input logic freeze, input logic [9:0] a, input logic [7:0] d);
		int i;
		start_op(1'b1, a, d);
		for (i = 0; i < 200 && !(link.wr && link.wdata[eeprom_pkg::CTRL_MWE_BIT]
			&& link.sel == eeprom_pkg::SEL_CTRL); i++) begin
			@(posedge i_clk);
			#1;
		end
		if (i >= 200) begin
			errors++;
			$display("FAIL t=%0t enable write not seen", $time);
			report_and_stop();
		end
		@(posedge i_clk);
		if (freeze) begin
			host_ce <= 1'b0;
			repeat (8) @(posedge i_clk);
			host_ce <= 1'b1;
		end else begin
			fbusy <= 1'b1;
		end
		wait_lvl(done, 1'b1);
		check(wact, 1'b0);
		drive(4'h0);
	endtask
	// main sequence
	initial begin
		logic [9:0] al [4];
		errors = 0;
		n_tests = 0;
		{start_w, start_r, irq_en, gie, fbusy, pdn} = '0;
		host_ce = 1'b1;
		addr = '0;
		data = '0;
		i_srst = 1'b1;
		i_por = 1'b1;
		void'($urandom(32'h0db94adb));
		repeat (16) @(posedge i_clk);
		i_srst <= 1'b0;
		i_por <= 1'b0;
		al = '{10'h000, 10'h3FF, 10'($urandom), 10'($urandom)};
		foreach (al[k]) op(1'b1, al[k], 8'($urandom));
		foreach (al[k]) rd_chk(al[k]);
		$display("test boundaries done");
		drive(4'hC);
		op(1'b1, 10'h155, 8'hA5);
		wait_lvl(wact, 1'b1);
		check(irq, 1'b0);
		wait_lvl(wact, 1'b0);
		repeat (2) @(posedge i_clk);
		#1 check(irq, 1'b1);
		drive(4'h8);
		repeat (2) @(posedge i_clk);
		#1 check(irq, 1'b0);
		drive(4'h4);
		rd_chk(10'h155);
		check(irq, 1'b0);
		$display("test ready irq done");
		drive(4'h2);
		start_op(1'b1, 10'h2AA, 8'h3C);
		repeat (20) @(posedge i_clk);
		#1 check(wact, 1'b0);
		drive(4'h0);
		wait_lvl(done, 1'b1);
		mem[10'h2AA] = 8'h3C;
		rd_chk(10'h2AA);
		$display("test flash busy done");
		spoil_strobe(1'b1, 10'h2AA, 8'h11);
		rd_chk(10'h2AA);
		spoil_strobe(1'b0, 10'h155, 8'h22);
		rd_chk(10'h155);
		$display("test refused strobe done");
		drive(4'h1);
		op(1'b1, 10'h0F0, 8'h5A);
		wait_lvl(wact, 1'b0);
		repeat (2) @(posedge i_clk);
		#1 check(pd_held, 1'b1);
		drive(4'h0);
		repeat (2) @(posedge i_clk);
		#1 check(pd_held, 1'b0);
		rd_chk(10'h0F0);
		$display("test power-down done");
		op(1'b1, 10'h3C3, 8'hC3);
		wait_lvl(wact, 1'b1);
		@(posedge i_clk);
		i_srst <= 1'b1;
		@(posedge i_clk);
		i_srst <= 1'b0;
		#1 check(wact, 1'b1);
		rd_chk(10'h3C3);
		rd_chk(10'h3FF);
		$display("test reset in write done");
		report_and_stop();
	end
endmodule // eeprom_access_control_tb_top
`default_nettype wire
